// ---- renc_top.sv ----
// Output stage of a magnetic rotary position sensor.
// What this block does
// (R1) Default mode drives quadrature A and B.
// (R2) Unprogrammed mode setting means quadrature output.
// (R3) Single-channel mode: pin one follows position LSB.
// (R4) Single-channel mode: pin two shows rotation direction.
// (R5) Index pulse once per turn, one or three steps.
// (R6) Index sits at programmable zero position.
// (R7) Commutation mode gives U V W, one/two pole pairs.
// (R8) Commutation mode puts LSB on pulse-width pin.
// (R9) Incremental resolution is 10, 9, 8 or 7 bits.
// (R10) Absolute angle has 10 bits, 1024 positions.
// (R11) Stored configuration input sets mode, resolution, zero.
// (R12) Programming input shifts chained serial data through.
// (R13) Select high keeps serial output high impedance.
// (R14) Host clocks, selects and reads serial port.
// (R15) Pulse width is position plus one microseconds.
// (R16) Pulse-width output repeats near one kilohertz.
// (R17) Closer flag: open drain, low on approach.
// (R18) Farther flag: open drain, low on retreat.
// (R19) Frame: ten angle bits MSB first, then status.
// (R20) Load at first falling clock, shift on rising.
// (R21) Both flags asserted means field out of range.
// (R22) A leads B clockwise, lags counter-clockwise.
// (R23) Configuration is static after power-up.
`timescale 1ns/1ps
`include "renc_defines.svh"
module renc_top
  import renc_pkg::*;
(
  input  wire logic         clock,            // System clock, 25 MHz.
  input  wire logic         reset_n,          // Asynchronous reset.
  input  wire logic [9:0]   angle_in,         // Measured angle.
  input  wire renc_status_t status_in,        // Measurement status.
  input  wire renc_cfg_t    cfg_in,           // Stored configuration.
  input  wire logic         ssi_clk,          // Serial clock pin.
  input  wire logic         select_n,         // Serial select pin.
  input  wire logic         prog_in,          // Programming/chain pin.
  output logic              data_out_q,       // Serial data.
  output logic              data_out_oe_q,    // Serial data enable.
  output logic              a_lsb_u_q,        // Incremental pin one.
  output logic              b_dir_v_q,        // Incremental pin two.
  output logic              index_w_q,        // Incremental pin three.
  output logic              pwm_lsb_q,        // Pulse-width or LSB.
  output logic              field_closer_n_q, // Closer flag level.
  output logic              field_closer_oe_q,// Closer flag enable.
  output logic              field_farther_n_q,// Farther flag level.
  output logic              field_farther_oe_q// Farther flag enable.
);

  localparam int AW = `RENC_ANGLE_W;

  // Scales a relative angle down to the programmed resolution.
  function automatic logic [9:0] renc_reduce(
    input logic [9:0] pos,
    input logic [1:0] res
  );
    logic [9:0] r;
    r = pos >> res; // R9
    return r;
  endfunction

  // Largest step count at a given resolution.
  function automatic logic [9:0] renc_top_step(input logic [1:0] res);
    logic [9:0] m;
    m = 10'h3ff >> res;
    return m;
  endfunction

  renc_cfg_t    cfg_q;
  logic [9:0]   angle_q;
  logic [9:0]   prev_q;
  logic         dir_q;
  logic [1:0]   sel_sync_q;
  logic         sel_n_s;
  renc_frame_t  frame_q;
  renc_frame_t  frame_d;
  logic         pwm_q;
  logic         link_pwm;
  logic [9:0]   rel_pos;
  logic [9:0]   step;
  logic [9:0]   step_max;
  logic         quad_a;
  logic         quad_b;
  logic         index_on;
  logic [9:0]   elec;
  logic [12:0]  sect_prod;
  logic [2:0]   sector;
  logic         ph_u;
  logic         ph_v;
  logic         ph_w;
  logic         mode_single;
  logic         mode_comm;
  logic         frame_rst_n;
  logic [9:0]   diff;

  // Configuration is sampled once after reset release and then held.
  logic         cfg_taken_q;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_q       <= '0;
      cfg_taken_q <= 1'b0;
    end
    else if (!cfg_taken_q)
    begin
      cfg_q       <= cfg_in; // R23 R11
      cfg_taken_q <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      angle_q <= 10'h000;
    else
      angle_q <= angle_in[AW-1:0]; // R10
  end

  // Select is a pin and passes two flip-flops first.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      sel_sync_q <= 2'b11;
    else
      sel_sync_q <= {sel_sync_q[0], select_n};
  end

  assign sel_n_s = sel_sync_q[1];

  // Only modes one and two of the code are special; every other
  // code falls back to quadrature.
  assign mode_single = (cfg_q.mode == `RENC_MODE_SINGLE);
  assign mode_comm   = (cfg_q.mode == `RENC_MODE_COMM);

  assign rel_pos  = angle_q - cfg_q.zero_pos; // R6
  assign step     = renc_reduce(rel_pos, cfg_q.res);
  assign step_max = renc_top_step(cfg_q.res);

  // A is high for counts 1 and 2 of each group of four, B for 2
  // and 3, so A moves first while the count rises.
  assign quad_a = step[1] ^ step[0]; // R22
  assign quad_b = step[1]; // R22

  assign index_on = (step == 10'h000) ||
                    (cfg_q.index_wide &&
                     (step == 10'h001 || step == step_max)); // R5 R6

  assign elec      = cfg_q.two_pole_pairs ? (rel_pos << 1) : rel_pos;
  assign sect_prod = {3'h0, elec} * {10'h000, `RENC_SECTORS};
  assign sector    = sect_prod[12:10];

  assign ph_u = (sector <= 3'h2); // R7
  assign ph_v = (sector >= 3'h2) && (sector <= 3'h4); // R7
  assign ph_w = (sector >= 3'h4) || (sector == 3'h0); // R7

  // Direction uses the shortest way round between two samples.
  assign diff = angle_q - prev_q;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prev_q <= 10'h000;
      dir_q  <= 1'b1;
    end
    else
    begin
      prev_q <= angle_q;
      if (diff != 10'h000)
        dir_q <= ~diff[AW-1]; // R4
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      a_lsb_u_q <= 1'b0;
      b_dir_v_q <= 1'b0;
      index_w_q <= 1'b0;
    end
    else if (mode_comm)
    begin
      a_lsb_u_q <= ph_u; // R7
      b_dir_v_q <= ph_v; // R7
      index_w_q <= ph_w; // R7
    end
    else if (mode_single)
    begin
      a_lsb_u_q <= step[0]; // R3
      b_dir_v_q <= dir_q; // R4
      index_w_q <= index_on; // R5
    end
    else
    begin
      a_lsb_u_q <= quad_a; // R1 R2
      b_dir_v_q <= quad_b; // R1 R2
      index_w_q <= index_on; // R5
    end
  end

  renc_pwm u_pwm (
    .clock   (clock),
    .reset_n (reset_n),
    .angle   (angle_q),
    .pwm_q   (pwm_q)
  );

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      pwm_lsb_q <= 1'b0;
    else if (mode_comm)
      pwm_lsb_q <= angle_q[0]; // R8
    else
      pwm_lsb_q <= pwm_q; // R15 R16
  end

  // An open-drain flag drives low only while asserted; both at once
  // tell the host the field is out of range.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      field_closer_n_q   <= 1'b0;
      field_closer_oe_q  <= 1'b0;
      field_farther_n_q  <= 1'b0;
      field_farther_oe_q <= 1'b0;
    end
    else
    begin
      field_closer_n_q   <= 1'b0;
      field_closer_oe_q  <= status_in.mag_inc; // R17 R21
      field_farther_n_q  <= 1'b0;
      field_farther_oe_q <= status_in.mag_dec; // R18 R21
    end
  end

  always_comb
  begin
    frame_d         = '0;
    frame_d.angle   = angle_q; // R19
    frame_d.ocf     = status_in.ocf;
    frame_d.cof     = status_in.cof;
    frame_d.lin     = status_in.lin;
    frame_d.mag_inc = status_in.mag_inc;
    frame_d.mag_dec = status_in.mag_dec;
    frame_d.par     = ^{angle_q, status_in}; // R19
  end

  // The frame word only moves while the device is deselected, so it
  // is static by the time the serial side loads it.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      frame_q <= '0;
    else if (sel_n_s)
      frame_q <= frame_d;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      data_out_oe_q <= 1'b0;
    else
      data_out_oe_q <= ~sel_n_s; // R13
  end

  // The frame ends with select itself, since the serial clock may
  // stop as soon as the last bit is read.
  assign frame_rst_n = reset_n & ~select_n;

  renc_ssi_link u_link (
    .ssi_clk     (ssi_clk),
    .frame_rst_n (frame_rst_n),
    .chain_in    (prog_in),
    .frame       (frame_q),
    .data_out_q  (link_pwm)
  );

  always_comb
  begin
    data_out_q = link_pwm; // R20
  end

endmodule // renc_top

// ---- renc_defines.svh ----
// Constants of the rotary encoder output block.
`ifndef RENC_DEFINES_SVH
`define RENC_DEFINES_SVH

`define RENC_ANGLE_W        10
`define RENC_FRAME_W        16
`define RENC_MODE_QUAD      2'h0
`define RENC_MODE_SINGLE    2'h1
`define RENC_MODE_COMM      2'h2
`define RENC_RES_10         2'h0
`define RENC_RES_9          2'h1
`define RENC_RES_8          2'h2
`define RENC_RES_7          2'h3
`define RENC_SECTORS        3'h6
`define RENC_CLK_MHZ        25
`define RENC_TICK_US        1
`define RENC_TICK_CYC       (`RENC_CLK_MHZ * `RENC_TICK_US)
`define RENC_PWM_PERIOD_US  1025
`define RENC_ZERO_RESET     10'h000

`endif

// ---- renc_pkg.sv ----
// Types shared by the rotary encoder output block.
package renc_pkg;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] res;
    logic       index_wide;
    logic       two_pole_pairs;
    logic [9:0] zero_pos;
  } renc_cfg_t;

  typedef struct packed {
    logic [9:0] angle;
    logic       ocf;
    logic       cof;
    logic       lin;
    logic       mag_inc;
    logic       mag_dec;
    logic       par;
  } renc_frame_t;

  typedef struct packed {
    logic ocf;
    logic cof;
    logic lin;
    logic mag_inc;
    logic mag_dec;
  } renc_status_t;

  typedef enum logic {
    RENC_PWM_HIGH,
    RENC_PWM_LOW
  } renc_pwm_st_t;

endpackage

// ---- renc_pwm.sv ----
// Pulse-width generator: high for angle plus one microsecond per frame.
`timescale 1ns/1ps
`include "renc_defines.svh"
module renc_pwm
  import renc_pkg::*;
(
  input  wire logic       clock,    // System clock.
  input  wire logic       reset_n,  // Asynchronous reset.
  input  wire logic [9:0] angle,    // Absolute angle to encode.
  output logic            pwm_q     // Pulse-width output.
);

  localparam logic [4:0]  TICK_MAX   = 5'(`RENC_TICK_CYC - 1);
  localparam logic [10:0] PERIOD_MAX = 11'(`RENC_PWM_PERIOD_US - 1);

  logic [4:0]   tick_q;
  logic [10:0]  us_q;
  logic [10:0]  width_q;
  renc_pwm_st_t st_q;
  logic         tick;

  assign tick = (tick_q == TICK_MAX);

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      tick_q <= 5'h00;
    else if (tick)
      tick_q <= 5'h00;
    else
      tick_q <= tick_q + 5'h01;
  end

  // The width is latched at the frame start so a moving angle never
  // cuts a pulse short.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      us_q    <= 11'h000;
      width_q <= 11'h001;
    end
    else if (tick)
    begin
      if (us_q == PERIOD_MAX)
      begin
        us_q    <= 11'h000;
        width_q <= {1'b0, angle} + 11'h001; // R15
      end
      else
        us_q <= us_q + 11'h001; // R16
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q  <= RENC_PWM_HIGH;
      pwm_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        RENC_PWM_HIGH:
          if (tick && us_q == PERIOD_MAX)
            st_q <= RENC_PWM_HIGH;
          else if (us_q >= width_q)
            st_q <= RENC_PWM_LOW;
        RENC_PWM_LOW:
          if (tick && us_q == PERIOD_MAX)
            st_q <= RENC_PWM_HIGH;
        default:
          st_q <= RENC_PWM_HIGH;
      endcase
      pwm_q <= (us_q < width_q); // R15
    end
  end

endmodule // renc_pwm

// ---- renc_ssi_link.sv ----
// Serial readout shift logic running on the host's serial clock.
`timescale 1ns/1ps
`include "renc_defines.svh"
module renc_ssi_link
  import renc_pkg::*;
(
  input  wire logic        ssi_clk,      // Serial clock from host.
  input  wire logic        frame_rst_n,  // Low outside a frame.
  input  wire logic        chain_in,     // Daisy-chain data input.
  input  wire renc_frame_t frame,        // Word held stable in frame.
  output logic             data_out_q    // Serial data output.
);

  logic [15:0] hold_q;
  logic        loaded_q;
  logic [15:0] shift_q;
  logic        first_q;

  // The word is frozen by the system side two clocks after select falls, so it
  // is static when the first falling edge captures it.
  always_ff @(negedge ssi_clk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      hold_q   <= 16'h0000;
      loaded_q <= 1'b0;
    end
    else if (!loaded_q)
    begin
      hold_q   <= frame; // R20 R19
      loaded_q <= 1'b1;
    end
  end

  always_ff @(posedge ssi_clk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      shift_q    <= 16'h0000;
      first_q    <= 1'b1;
      data_out_q <= 1'b1;
    end
    else if (loaded_q)
    begin
      first_q <= 1'b0;
      if (first_q)
      begin
        data_out_q <= hold_q[15]; // R20
        shift_q    <= {hold_q[14:0], chain_in}; // R12
      end
      else
      begin
        data_out_q <= shift_q[15]; // R20
        shift_q    <= {shift_q[14:0], chain_in}; // R12
      end
    end
  end

endmodule // renc_ssi_link

// ---- renc_top_properties.sv ----
// Port-level assertions for the encoder output stage.
`timescale 1ns/1ps
module renc_top_properties
  import renc_pkg::*;
(
  input wire logic         clock,              // Clock.
  input wire logic         reset_n,            // Reset.
  input wire logic [9:0]   angle_in,           // Angle.
  input wire renc_status_t status_in,          // Status.
  input wire renc_cfg_t    cfg_in,             // Setup.
  input wire logic         select_n,           // Select.
  input wire logic         data_out_oe_q,      // Data enable.
  input wire logic         a_lsb_u_q,          // Pin one.
  input wire logic         b_dir_v_q,          // Pin two.
  input wire logic         index_w_q,          // Pin three.
  input wire logic         pwm_lsb_q,          // Pulse pin.
  input wire logic         field_closer_n_q,   // Closer level.
  input wire logic         field_closer_oe_q,  // Closer enable.
  input wire logic         field_farther_n_q,  // Farther level.
  input wire logic         field_farther_oe_q  // Farther enable.
);
  logic [1:0] up_q;
  logic [9:0] rel, stp, e;
  logic [2:0] sec;
  logic       single, comm, quad, idx;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Settle counter keeps pre-reset history out of the windows.
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  assign rel = angle_in - cfg_in.zero_pos;
  assign stp = rel >> cfg_in.res;
  assign e = cfg_in.two_pole_pairs ? {rel[8:0], 1'h0} : rel;
  assign sec = 3'((13'(e) * 13'h6) >> 10);
  assign single = cfg_in.mode == 2'h1;
  assign comm = cfg_in.mode == 2'h2;
  assign quad = !single && !comm;
  assign idx = stp == 10'h0 || (cfg_in.index_wide && (stp == 10'h1
               || stp == (10'h3ff >> cfg_in.res)));
  sequence calm;
    up_q == 2'h3 ##0 $stable(angle_in) [*3];
  endsequence
  a_flag_levels: assert property (!field_closer_n_q && !field_farther_n_q)
    else $error("flag level not low");
  a_closer_flag: assert property (up_q == 2'h3 ##0
    $stable(status_in.mag_inc) [*4] |-> field_closer_oe_q == status_in.mag_inc)
    else $error("closer flag wrong");
  a_farther_flag: assert property (up_q == 2'h3 ##0
    $stable(status_in.mag_dec) [*4] |-> field_farther_oe_q == status_in.mag_dec)
    else $error("farther flag wrong");
  a_oe_release: assert property (select_n [*4] |-> !data_out_oe_q)
    else $error("data driven while deselected");
  a_oe_drive: assert property (!select_n [*4] |-> data_out_oe_q)
    else $error("data not driven while selected");
  a_quad_pins: assert property (calm ##0 quad |->
    a_lsb_u_q == (stp[1] ^ stp[0]) && b_dir_v_q == stp[1])
    else $error("quadrature pins wrong");
  a_single_lsb: assert property (calm ##0 single |-> a_lsb_u_q == stp[0])
    else $error("single channel pin wrong");
  a_index_pulse: assert property (calm ##0 !comm |-> index_w_q == idx)
    else $error("index pin wrong");
  a_comm_phases: assert property (calm ##0 comm |->
    a_lsb_u_q == (sec <= 3'h2) && b_dir_v_q == (sec >= 3'h2 && sec <= 3'h4)
    && index_w_q == (sec >= 3'h4 || sec == 3'h0) && pwm_lsb_q == angle_in[0])
    else $error("commutation pins wrong");
  c_frame: cover property ($fell(select_n));
  c_comm: cover property (comm && pwm_lsb_q);
  c_index: cover property (index_w_q);
endmodule // renc_top_properties

// ---- renc_host_model.sv ----
// Host controller model that clocks and reads the serial port.
`timescale 1ns/1ps
module renc_host_model
(
  input  wire logic dq,        // Serial data level.
  input  wire logic oe,        // Serial data enable.
  output logic      ssi_clk,   // Serial clock.
  output logic      select_n,  // Select, active low.
  output logic      prog_in    // Chain data.
);
  logic last_q;
  logic lvl;
  // A released line shows the inverse of its last driven level.
  always @(dq or oe) if (oe) last_q = dq;
  assign lvl = oe ? dq : ~last_q;
  initial
  begin
    ssi_clk = 1'h1;
    select_n = 1'h1;
    prog_in = 1'h0;
    last_q = 1'h0;
  end
  // Clock stands high outside frames; hp sets the host speed.
  task automatic read_bits(input int n, input logic chain, input int hp,
                           output logic [16:0] w);
    w = 17'h0;
    prog_in = chain;
    select_n = 1'h0;
    #200;
    for (int i = 0; i <= n; i++)
    begin
      #hp;
      if (i > 0) w = {w[15:0], lvl};
      ssi_clk = 1'h0;
      #hp;
      ssi_clk = 1'h1;
    end
    #hp;
    select_n = 1'h1;
    prog_in = 1'h0;
    // Deselect long enough for the link to reset before the next frame.
    #200;
  endtask
endmodule // renc_host_model

// ---- renc_top_tb_top.sv ----
// Self-checking bench for the encoder output stage.
`timescale 1ns/1ps
module renc_top_tb_top
  import renc_pkg::*;
;
  logic         clock, reset_n, ssi_clk, select_n, prog_in;
  logic         data_out_q, data_out_oe_q, a_lsb_u_q, b_dir_v_q;
  logic         index_w_q, pwm_lsb_q, field_closer_n_q;
  logic         field_closer_oe_q, field_farther_n_q, field_farther_oe_q;
  logic [9:0]   angle_in;
  renc_status_t status_in;
  renc_cfg_t    cfg_in;
  int           n_mismatch, compares, cyc;

  renc_top u_dut (.clock, .reset_n, .angle_in, .status_in, .cfg_in,
    .ssi_clk, .select_n, .prog_in, .data_out_q, .data_out_oe_q, .a_lsb_u_q,
    .b_dir_v_q, .index_w_q, .pwm_lsb_q, .field_closer_n_q,
    .field_closer_oe_q, .field_farther_n_q, .field_farther_oe_q);
  renc_host_model u_host (.dq(data_out_q), .oe(data_out_oe_q), .ssi_clk,
    .select_n, .prog_in);

  always #20 clock = ~clock;

  task automatic chk(input logic [16:0] seen, exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    if (n_mismatch == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic boot(input logic [1:0] m, r, input logic wd, pp);
    @(negedge clock);
    reset_n = 1'h0;
    cfg_in = {m, r, wd, pp, 10'h005};
    repeat (3) @(negedge clock);
    reset_n = 1'h1;
    @(negedge clock);
  endtask

  task automatic go(input logic [9:0] ang, input int n);
    angle_in = ang;
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic t_quad;
    logic [9:0] s;
    for (int r = 0; r < 4; r++)
    begin
      boot(r == 2 ? 2'h3 : 2'h0, 2'(r), 1'h0, 1'h0);
      for (int k = -1; k < 6; k++)
      begin
        s = 10'(k) & (10'h3ff >> r);
        go(10'h005 + (10'(k) << r), 4);
        chk(a_lsb_u_q, s[1] ^ s[0], "a");
        chk(b_dir_v_q, s[1], "b");
        chk(index_w_q, s == 10'h0, "index");
      end
    end
  endtask

  task automatic t_single;
    logic [9:0] s;
    boot(2'h1, 2'h0, 1'h1, 1'h0);
    go(10'h002, 4);
    for (int i = 0; i < 12; i++)
    begin
      s = 10'(i < 6 ? i - 2 : 8 - i);
      go(10'h005 + s, 3);
      chk(a_lsb_u_q, s[0], "lsb");
      chk(b_dir_v_q, i < 6, "dir");
      chk(index_w_q, s < 10'h2 || s == 10'h3ff, "wide index");
    end
  endtask

  task automatic t_comm;
    logic [9:0] e;
    logic [2:0] q;
    for (int p = 0; p < 2; p++)
    begin
      boot(2'h2, 2'h0, 1'h0, 1'(p));
      for (int k = 0; k < 12; k++)
      begin
        e = 10'(k * 85) << p;
        q = 3'(int'(e) * 6 / 1024);
        go(10'h005 + 10'(k * 85), 4);
        chk({a_lsb_u_q, b_dir_v_q, index_w_q}, {q <= 3'h2,
          q >= 3'h2 && q <= 3'h4, q >= 3'h4 || q == 3'h0}, "uvw");
        chk(pwm_lsb_q, angle_in[0], "pwm lsb");
      end
    end
  endtask

  task automatic t_serial;
    logic [16:0] got;
    logic [14:0] f;
    boot(2'h0, 2'h0, 1'h0, 1'h0);
    status_in = 5'h1b;
    go(10'h2c5, 4);
    chk({field_closer_oe_q, field_farther_oe_q, field_closer_n_q,
      field_farther_n_q}, 4'hc, "flags");
    chk(data_out_oe_q, 1'h0, "oe idle");
    f = {10'h2c5, 5'h1b};
    u_host.read_bits(5, 1'h1, 16, got);
    u_host.read_bits(17, 1'h1, 16, got);
    chk(got, {f, ^f, 1'h1}, "frame");
    status_in = 5'h02;
    go(10'h13a, 4);
    f = {10'h13a, 5'h02};
    u_host.read_bits(17, 1'h0, 40, got);
    chk(got, {f, ^f, 1'h0}, "slow frame");
    chk({field_closer_oe_q, field_farther_oe_q}, 2'h2, "closer");
  endtask

  task automatic t_pwm;
    int lo;
    int hi;
    lo = 0;
    hi = 0;
    angle_in = 10'h3ff;
    boot(2'h0, 2'h0, 1'h0, 1'h0);
    while (pwm_lsb_q !== 1'h1) @(negedge clock);
    while (pwm_lsb_q !== 1'h0) @(negedge clock);
    while (pwm_lsb_q !== 1'h1) @(negedge clock);
    while (pwm_lsb_q === 1'h1)
    begin
      hi++;
      @(negedge clock);
    end
    while (pwm_lsb_q !== 1'h1)
    begin
      lo++;
      @(negedge clock);
    end
    chk(17'(hi), 17'(25 * 1024), "pwm width");
    chk(17'(lo + hi), 17'(25 * 1025), "pwm period");
  endtask

  initial
  begin
    clock = 1'h0;
    reset_n = 1'h0;
    angle_in = 10'h0;
    status_in = 5'h0;
    cfg_in = 16'h0;
    n_mismatch = 0;
    compares = 0;
    cyc = 0;
    t_quad();
    t_single();
    t_comm();
    t_serial();
    t_pwm();
    report_and_stop();
  end
endmodule // renc_top_tb_top

bind renc_top renc_top_properties u_props (.clock, .reset_n, .angle_in,
  .status_in, .cfg_in, .select_n, .data_out_oe_q, .a_lsb_u_q, .b_dir_v_q,
  .index_w_q, .pwm_lsb_q, .field_closer_n_q, .field_closer_oe_q,
  .field_farther_n_q, .field_farther_oe_q);
